//--- mer_adv_regs.v
`timescale 1ns/1ps
`include "mer_defs_regs.vh"
// Contract
// - engine initialization never loads values into the advanced configuration registers
// - refresh bit set at engine initialization starts a fast buffer refill
// - each new sensor sample sets the new-sample flag
// - each motion event updates the detection origin bit, 0 normal, 1 extended
// - detected noise sets the noise flag; motion events may be suppressed
// - detected transient sets the transient flag; motion events may be suppressed
// - lock level bits 7:5 set minimum accepted slope change
// - window size bits 4:3 select small, medium, large; zero reserved
// - limits recalculated every four plus twice update-rate samples
// - process rate is 16-bit read-only, upper byte at lower address
// - current sensor sample readable as 16-bit value at two bytes
// - calculated dc level readable as 16-bit value at two bytes
// - averaging register steers how much the engine averages samples
module mer_adv_regs #(
    parameter ADDR_W = 12
) (
    input  wire              sys_clk_in,
    input  wire              sys_rst_in,
    input  wire              psel_in,
    input  wire              penable_in,
    input  wire              pwrite_in,
    input  wire [ADDR_W-1:0] paddr_in,
    input  wire [31:0]       pwdata_in,
    output wire [31:0]       prdata_out,
    output wire              pready_out,
    output wire              pslverr_out,
    input  wire              eng_init_in,
    input  wire              eng_sample_valid_in,
    input  wire [15:0]       eng_sample_in,
    input  wire              eng_motion_in,
    input  wire              eng_origin_ext_in,
    input  wire              eng_noise_in,
    input  wire              eng_transient_in,
    input  wire              eng_dc_valid_in,
    input  wire [15:0]       eng_dc_in,
    input  wire [15:0]       eng_rate_in,
    output wire              fast_fill_out,
    output wire              limit_update_out,
    output wire              window_valid_out,
    output wire [2:0]        lock_level_out,
    output wire [1:0]        window_size_out,
    output wire [7:0]        sample_avg_out,
    output wire [7:0]        debounce_time_out,
    output wire [7:0]        debounce_batch_out,
    output wire [6:0]        transient_sense_out,
    output wire [6:0]        noise_sense_out
);

    // ==========================================================
    // bus decode
    wire       setup_phase;
    wire       wr_take;
    wire       rd_take;
    wire       err_now;
    wire [9:0] idx;
    wire       aligned;
    reg        mapped;
    reg        is_ro;
    reg        pslverr_q;

    assign setup_phase = psel_in & ~penable_in;
    assign wr_take     = psel_in & penable_in & pwrite_in & ~pslverr_q;
    assign idx         = paddr_in[ADDR_W-1:2];
    assign aligned     = (paddr_in[1:0] == 2'h0);
    assign rd_take     = ~pwrite_in & mapped & aligned;
    assign err_now     = ~(mapped & aligned) | (pwrite_in & is_ro);

    always @* begin
        mapped = 1'b1;
        is_ro  = 1'b0;
        case (idx)
            `MER_IDX_ASC0, `MER_IDX_ASC2, `MER_IDX_AVG,
            `MER_IDX_DEB_TIME, `MER_IDX_DEB_BATCH,
            `MER_IDX_TRN_SENSE, `MER_IDX_NSE_SENSE: begin
                is_ro = 1'b0;
            end
            `MER_IDX_RATE_HI, `MER_IDX_RATE_LO, `MER_IDX_SIG_HI,
            `MER_IDX_SIG_LO, `MER_IDX_DC_HI, `MER_IDX_DC_LO: begin
                is_ro = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // configuration storage
    reg        refresh_q;
    reg        origin_q;
    reg [7:0]  asc2_q;
    reg [7:0]  avg_q;
    reg [7:0]  deb_time_q;
    reg [7:0]  deb_batch_q;
    reg [6:0]  trn_sense_q;
    reg [6:0]  nse_sense_q;
    reg [15:0] rate_q;
    reg [15:0] sig_q;
    reg [15:0] dc_q;
    reg [7:0]  low_shadow_q;
    reg [31:0] prdata_q;
    reg        fast_fill_q;
    reg        window_valid_q;
    wire       new_smp;
    wire       noise_flag;
    wire       trn_flag;
    wire       wr_asc0;
    wire       wr_asc2;
    wire       clr_new_smp;
    wire       clr_noise;
    wire       clr_trn;
    wire       limit_restart;

    assign wr_asc0       = wr_take & (idx == `MER_IDX_ASC0);
    assign wr_asc2       = wr_take & (idx == `MER_IDX_ASC2);
    assign clr_new_smp   = wr_asc0 & ~pwdata_in[`MER_ASC0_NEW_SMP];
    assign clr_noise     = wr_asc0 & ~pwdata_in[`MER_ASC0_NOISE];
    assign clr_trn       = wr_asc0 & ~pwdata_in[`MER_ASC0_TRANSIENT];
    assign limit_restart = fast_fill_q | wr_asc2;

    // system reset clears; engine initialization leaves these alone
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            refresh_q   <= `MER_RST_FLAG;
            asc2_q      <= `MER_RST_BYTE;
            avg_q       <= `MER_RST_BYTE;
            deb_time_q  <= `MER_RST_BYTE;
            deb_batch_q <= `MER_RST_BYTE;
            trn_sense_q    <= `MER_RST_SENSE;
            nse_sense_q    <= `MER_RST_SENSE;
            window_valid_q <= `MER_RST_FLAG;
        end else if (wr_take) begin
            case (idx)
                `MER_IDX_ASC0: begin
                    refresh_q <= pwdata_in[`MER_ASC0_REFRESH];
                end
                `MER_IDX_ASC2: begin
                    asc2_q         <= pwdata_in[7:0];
                    window_valid_q <= (pwdata_in[`MER_ASC2_WIN_HI:`MER_ASC2_WIN_LO]
                                       != `MER_WIN_RESERVED);
                end
                `MER_IDX_AVG: begin
                    avg_q <= pwdata_in[7:0];
                end
                `MER_IDX_DEB_TIME: begin
                    deb_time_q <= pwdata_in[7:0];
                end
                `MER_IDX_DEB_BATCH: begin
                    deb_batch_q <= pwdata_in[7:0];
                end
                `MER_IDX_TRN_SENSE: begin
                    trn_sense_q <= pwdata_in[`MER_SENSE_W-1:0];
                end
                `MER_IDX_NSE_SENSE: begin
                    nse_sense_q <= pwdata_in[`MER_SENSE_W-1:0];
                end
                default: begin
                    refresh_q <= refresh_q;
                end
            endcase
        end
    end

    // ==========================================================
    // engine-set flags
    mer_flag u_new_smp (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (eng_sample_valid_in),
        .clr_in     (clr_new_smp),
        .flag_out   (new_smp)
    );

    mer_flag u_noise (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (eng_noise_in),
        .clr_in     (clr_noise),
        .flag_out   (noise_flag)
    );

    mer_flag u_transient (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (eng_transient_in),
        .clr_in     (clr_trn),
        .flag_out   (trn_flag)
    );

    // ==========================================================
    // engine observables
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            origin_q    <= `MER_RST_FLAG;
            rate_q      <= `MER_RST_WORD;
            sig_q       <= `MER_RST_WORD;
            dc_q        <= `MER_RST_WORD;
            fast_fill_q <= `MER_RST_FLAG;
        end else begin
            rate_q      <= eng_rate_in;
            fast_fill_q <= eng_init_in & refresh_q;
            if (eng_motion_in) begin
                origin_q <= eng_origin_ext_in;
            end
            if (eng_sample_valid_in) begin
                sig_q <= eng_sample_in;
            end
            if (eng_dc_valid_in) begin
                dc_q <= eng_dc_in;
            end
        end
    end

    // ==========================================================
    // control-limit timing, restarted on fast fill and on any advanced status/control 2 write
    wire [2:0] upd_rate;

    assign upd_rate = asc2_q[`MER_ASC2_UPD_HI:`MER_ASC2_UPD_LO];

    mer_limit_timer #(
        .RATE_W (3),
        .CNT_W  (5)
    ) u_limit_timer (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .restart_in (limit_restart),
        .sample_in  (eng_sample_valid_in),
        .rate_in    (upd_rate),
        .tick_out   (limit_update_out)
    );

    // ==========================================================
    // read path, data prepared in the setup phase
    reg  [7:0] rd_byte;
    wire [7:0] asc0_view;

    assign asc0_view = {3'h0, refresh_q, new_smp, origin_q, noise_flag, trn_flag};

    always @* begin
        rd_byte = `MER_RST_BYTE;
        case (idx)
            `MER_IDX_ASC0: begin
                rd_byte = asc0_view;
            end
            `MER_IDX_ASC2: begin
                rd_byte = asc2_q;
            end
            `MER_IDX_RATE_HI: begin
                rd_byte = rate_q[15:8];
            end
            `MER_IDX_RATE_LO: begin
                rd_byte = low_shadow_q;
            end
            `MER_IDX_AVG: begin
                rd_byte = avg_q;
            end
            `MER_IDX_DEB_TIME: begin
                rd_byte = deb_time_q;
            end
            `MER_IDX_DEB_BATCH: begin
                rd_byte = deb_batch_q;
            end
            `MER_IDX_TRN_SENSE: begin
                rd_byte = {1'b0, trn_sense_q};
            end
            `MER_IDX_NSE_SENSE: begin
                rd_byte = {1'b0, nse_sense_q};
            end
            `MER_IDX_SIG_HI: begin
                rd_byte = sig_q[15:8];
            end
            `MER_IDX_SIG_LO: begin
                rd_byte = low_shadow_q;
            end
            `MER_IDX_DC_HI: begin
                rd_byte = dc_q[15:8];
            end
            `MER_IDX_DC_LO: begin
                rd_byte = low_shadow_q;
            end
            default: begin
                rd_byte = `MER_RST_BYTE;
            end
        endcase
    end

    // reading an upper byte freezes its lower byte for the next read
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            low_shadow_q <= `MER_RST_BYTE;
            prdata_q     <= `MER_RST_BUS;
            pslverr_q    <= `MER_RST_FLAG;
        end else if (setup_phase) begin
            pslverr_q <= err_now;
            prdata_q  <= `MER_RST_BUS;
            if (rd_take) begin
                prdata_q <= {24'h000000, rd_byte};
                case (idx)
                    `MER_IDX_RATE_HI: begin
                        low_shadow_q <= rate_q[7:0];
                    end
                    `MER_IDX_SIG_HI: begin
                        low_shadow_q <= sig_q[7:0];
                    end
                    `MER_IDX_DC_HI: begin
                        low_shadow_q <= dc_q[7:0];
                    end
                    default: begin
                        low_shadow_q <= low_shadow_q;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // outputs
    assign prdata_out          = prdata_q;
    assign pready_out          = 1'b1;
    assign pslverr_out         = psel_in & penable_in & pslverr_q;
    assign fast_fill_out       = fast_fill_q;
    assign lock_level_out      = asc2_q[`MER_ASC2_LOCK_HI:`MER_ASC2_LOCK_LO];
    assign window_size_out     = asc2_q[`MER_ASC2_WIN_HI:`MER_ASC2_WIN_LO];
    assign window_valid_out    = window_valid_q;
    assign sample_avg_out      = avg_q;
    assign debounce_time_out   = deb_time_q;
    assign debounce_batch_out  = deb_batch_q;
    assign transient_sense_out = trn_sense_q;
    assign noise_sense_out     = nse_sense_q;

endmodule

//--- mer_adv_regs_monitor.sv
`timescale 1ns/1ps
`include "mer_defs_regs.vh"
// ==========================================================
// port checks of the advanced register bank
module mer_adv_regs_monitor (
    input        sys_clk_in,
    input        sys_rst_in,
    input        psel_in,
    input        penable_in,
    input        pwrite_in,
    input [11:0] paddr_in,
    input [31:0] pwdata_in,
    input [31:0] prdata_out,
    input        pslverr_out,
    input        eng_init_in,
    input        eng_sample_valid_in,
    input        eng_motion_in,
    input        eng_origin_ext_in,
    input        eng_noise_in,
    input        eng_transient_in,
    input        fast_fill_out,
    input        limit_update_out,
    input        window_valid_out,
    input [2:0]  lock_level_out,
    input [1:0]  window_size_out,
    input [7:0]  sample_avg_out
);
    wire wr = psel_in && penable_in && pwrite_in;
    wire rs = psel_in && !penable_in && !pwrite_in;
    wire s0 = paddr_in == {`MER_IDX_ASC0, 2'h0};
    wire s2 = paddr_in == {`MER_IDX_ASC2, 2'h0};
    wire sa = paddr_in == {`MER_IDX_AVG, 2'h0};
    wire sr = paddr_in == {`MER_IDX_RATE_HI, 2'h0};

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // ==========================================================
    // assertions
    a_init_keeps_cfg: assert property (eng_init_in && !wr |=>
        $stable(sample_avg_out) && $stable(lock_level_out)) else $error("init changed config");
    a_fill_after_init: assert property (fast_fill_out |-> $past(eng_init_in))
        else $error("fast fill without init");
    a_sample_flag_set: assert property (eng_sample_valid_in ##1 (rs && s0) |=> prdata_out[3])
        else $error("new sample flag not set");
    a_origin_bit_upd: assert property (eng_motion_in ##1 (rs && s0) |=>
        prdata_out[2] == $past(eng_origin_ext_in, 2)) else $error("origin bit wrong");
    a_noise_flag_set: assert property (eng_noise_in ##1 (rs && s0) |=> prdata_out[1])
        else $error("noise flag not set");
    a_trans_flag_set: assert property (eng_transient_in ##1 (rs && s0) |=> prdata_out[0])
        else $error("transient flag not set");
    a_ctrl_write_out: assert property (wr && s2 |=>
        {lock_level_out, window_size_out} == $past(pwdata_in[7:3])) else $error("ctrl field");
    a_window_valid: assert property (window_valid_out == (window_size_out != 2'h0))
        else $error("window valid wrong");
    a_limit_on_sample: assert property (limit_update_out |-> $past(eng_sample_valid_in))
        else $error("limit update without sample");
    a_ro_write_err: assert property (wr && sr |-> pslverr_out)
        else $error("read-only write accepted");
    a_avg_write_out: assert property (wr && sa |=> sample_avg_out == $past(pwdata_in[7:0]))
        else $error("averaging value wrong");

    c_fill: cover property (fast_fill_out);
    c_limit: cover property (limit_update_out);
    c_ro_write: cover property (wr && sr);
    c_origin: cover property (eng_motion_in ##1 (rs && s0));
endmodule

bind mer_adv_regs mer_adv_regs_monitor mer_adv_regs_monitor_i (.*);

//--- mer_adv_regs_tb.sv
`timescale 1ns/1ps
`include "mer_defs_regs.vh"
// ==========================================================
// self-checking bench with a byte model of the bank
module mer_adv_regs_tb;
    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [5:0]  ev = 6'h00;
    logic        eng_origin_ext_in = 1'b0;
    logic [15:0] eng_sample_in = 16'h0, eng_dc_in = 16'h0, eng_rate_in = 16'h0;
    wire         eng_init_in = ev[0], eng_sample_valid_in = ev[1], eng_motion_in = ev[2];
    wire         eng_noise_in = ev[3], eng_transient_in = ev[4], eng_dc_valid_in = ev[5];
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, fast_fill_out, limit_update_out, window_valid_out;
    wire  [2:0]  lock_level_out;
    wire  [1:0]  window_size_out;
    wire  [7:0]  sample_avg_out, debounce_time_out, debounce_batch_out;
    wire  [6:0]  transient_sense_out, noise_sense_out;
    int          m [16];
    int          shd, n_mismatch, cmp_count, i, k;
    logic [31:0] seed = 32'h776f, r_d;
    logic        r_e;

    mer_adv_regs mer_adv_regs_i (.*);

    always #20 sys_clk_in = ~sys_clk_in;

    // ==========================================================
    // helpers
    function automatic [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic bit bad(input bit w, input [9:0] ix);
        bad = ix < 10'h0f0 || ix > 10'h0fd || ix == 10'h0f1 ||
              (w && (ix == 10'h0f3 || ix == 10'h0f4 || ix >= 10'h0fa));
    endfunction

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            ev <= 6'h00;
        end
    endtask

    task automatic set_ev(input [5:0] e, input bit o);
        @(posedge sys_clk_in);
        ev <= e;
        eng_origin_ext_in <= o;
        eng_sample_in <= seed[15:0];
        eng_dc_in <= seed[31:16];
        m[0] |= (e[1] ? 8 : 0) | (e[3] ? 2 : 0) | (e[4] ? 1 : 0);
        if (e[2]) m[0] = (m[0] & 8'hfb) | (o << 2);
        if (e[1]) m[10] = seed[15:8];
        if (e[1]) m[11] = seed[7:0];
        if (e[5]) m[12] = seed[31:24];
        if (e[5]) m[13] = seed[23:16];
        seed = nx(seed);
    endtask

    task automatic apb(input bit w, input [9:0] ix, input [31:0] d);
        int n;
        @(posedge sys_clk_in);
        ev <= 6'h00;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= {ix, 2'h0};
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        r_d = prdata_out;
        r_e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic wr(input [9:0] ix, input [7:0] d);
        int j;
        j = ix - 10'h0f0;
        apb(1'b1, ix, {24'h0, d});
        chk(r_e, bad(1'b1, ix));
        if (!bad(1'b1, ix)) begin
            if (j == 0) m[0] = (d & 8'h10) | (m[0] & 8'h04) | (m[0] & d & 8'h0b);
            else if (j >= 8) m[j] = d & 8'h7f;
            else m[j] = d;
        end
    endtask

    task automatic rd(input [9:0] ix);
        int j, e;
        j = ix - 10'h0f0;
        e = 0;
        if (!bad(1'b0, ix)) e = (j == 4 || j == 11 || j == 13) ? shd : m[j];
        if (j == 3 || j == 10 || j == 12) shd = m[j + 1];
        apb(1'b0, ix, 32'h0);
        chk(r_d, e);
        chk(r_e, bad(1'b0, ix));
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        eng_rate_in <= seed[15:0];
        m[3] = seed[15:8];
        m[4] = seed[7:0];
        seed = nx(seed);
        for (i = 'h0ef; i <= 'h0fe; i++) rd(i[9:0]);
        if ((m[3] << 8 | m[4]) < 'h80) $display("process rate low %h", m[3] << 8 | m[4]);
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            for (i = 'h0f0; i <= 'h0fd; i++) begin
                wr(i[9:0], seed[7:0]);
                seed = nx(seed);
                rd(i[9:0]);
            end
            chk({sample_avg_out, debounce_time_out, debounce_batch_out}, m[5] << 16 | m[6] << 8 | m[7]);
            chk({lock_level_out, window_size_out, transient_sense_out, noise_sense_out},
                {m[2][7:3], m[8][6:0], m[9][6:0]});
        end
        for (i = 0; i < 4; i++) begin
            wr(`MER_IDX_ASC2, {3'h0, i[1:0], 3'h0});
            cyc(1);
            chk(window_size_out, i);
            chk(window_valid_out, i != 0);
        end
        $display("test config done");
        for (i = 1; i < 6; i++) begin
            set_ev(6'h01 << i, 1'b0);
            rd(`MER_IDX_ASC0);
            for (k = 'h0fa; k <= 'h0fd; k++) rd(k[9:0]);
        end
        set_ev(6'h04, 1'b1);
        rd(`MER_IDX_ASC0);
        for (k = 0; k < 4; k++) begin
            if (k != 2) begin
                wr(`MER_IDX_ASC0, ~(8'h01 << k) & 8'h1f);
                rd(`MER_IDX_ASC0);
            end
        end
        $display("test flags done");
        for (k = 0; k < 2; k++) begin
            wr(`MER_IDX_ASC0, {3'h0, k[0], 4'h0});
            set_ev(6'h01, 1'b0);
            cyc(2);
            chk(fast_fill_out, k);
            rd(`MER_IDX_ASC2);
        end
        $display("test refresh done");
        for (i = 0; i < 8; i++) begin
            wr(`MER_IDX_ASC2, i[7:0]);
            k = 0;
            do begin
                set_ev(6'h02, 1'b0);
                cyc(2);
                k++;
            end while (limit_update_out !== 1'b1 && k < 30);
            chk(k, 4 + 2 * i);
        end
        $display("test limit timer done");
        wrap_up();
    end
endmodule

//--- mer_defs_regs.vh
`ifndef MER_DEFS_REGS_VH
`define MER_DEFS_REGS_VH

// ==========================================================
// register indices, byte address is four times the index
`define MER_IDX_ASC0      10'h0f0
`define MER_IDX_ASC2      10'h0f2
`define MER_IDX_RATE_HI   10'h0f3
`define MER_IDX_RATE_LO   10'h0f4
`define MER_IDX_AVG       10'h0f5
`define MER_IDX_DEB_TIME  10'h0f6
`define MER_IDX_DEB_BATCH 10'h0f7
`define MER_IDX_TRN_SENSE 10'h0f8
`define MER_IDX_NSE_SENSE 10'h0f9
`define MER_IDX_SIG_HI    10'h0fa
`define MER_IDX_SIG_LO    10'h0fb
`define MER_IDX_DC_HI     10'h0fc
`define MER_IDX_DC_LO     10'h0fd

// ==========================================================
// advanced status/control 0 fields
`define MER_ASC0_REFRESH   4
`define MER_ASC0_NEW_SMP   3
`define MER_ASC0_ORIGIN    2
`define MER_ASC0_NOISE     1
`define MER_ASC0_TRANSIENT 0

// ==========================================================
// advanced status/control 2 fields
`define MER_ASC2_LOCK_HI 7
`define MER_ASC2_LOCK_LO 5
`define MER_ASC2_WIN_HI  4
`define MER_ASC2_WIN_LO  3
`define MER_ASC2_UPD_HI  2
`define MER_ASC2_UPD_LO  0
`define MER_WIN_RESERVED 2'h0
`define MER_WIN_SMALL    2'h1
`define MER_WIN_MEDIUM   2'h2
`define MER_WIN_LARGE    2'h3

// ==========================================================
// sensitivity registers keep bit 7 reserved
`define MER_SENSE_W 7

// ==========================================================
// control-limit period: base plus step times update rate
`define MER_UPD_BASE 5'h04
`define MER_UPD_STEP 5'h02

// ==========================================================
// reset values
`define MER_RST_BYTE  8'h00
`define MER_RST_WORD  16'h0000
`define MER_RST_FLAG  1'b0
`define MER_RST_CNT   5'h00
`define MER_RST_SENSE 7'h00
`define MER_RST_BUS   32'h00000000

`endif

//--- mer_flag.v
`timescale 1ns/1ps
// ==========================================================
// sticky engine-set flag, software writes zero to clear
module mer_flag (
    input  wire sys_clk_in,
    input  wire sys_rst_in,
    input  wire set_in,
    input  wire clr_in,
    output wire flag_out
);
`include "mer_defs_regs.vh"

    reg flag_q;
    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (clr_in) begin
            flag_d = 1'b0;
        end
        if (set_in) begin
            flag_d = 1'b1;
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            flag_q <= `MER_RST_FLAG;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;

endmodule

//--- mer_limit_timer.v
`timescale 1ns/1ps
// ==========================================================
// counts sensor samples and pulses when limits are due
module mer_limit_timer #(
    parameter RATE_W = 3,
    parameter CNT_W  = 5
) (
    input  wire              sys_clk_in,
    input  wire              sys_rst_in,
    input  wire              restart_in,
    input  wire              sample_in,
    input  wire [RATE_W-1:0] rate_in,
    output wire              tick_out
);
`include "mer_defs_regs.vh"

    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    reg              tick_q;
    reg              tick_d;
    wire [CNT_W-1:0] period;

    // period is four plus twice the update rate, in samples
    assign period = `MER_UPD_BASE + (`MER_UPD_STEP * {{(CNT_W-RATE_W){1'b0}}, rate_in});

    always @* begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (restart_in) begin
            cnt_d = `MER_RST_CNT;
        end else if (sample_in) begin
            if (cnt_q + 1'b1 >= period) begin
                cnt_d  = `MER_RST_CNT;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cnt_q  <= `MER_RST_CNT;
            tick_q <= `MER_RST_FLAG;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule
